// >>> logic/acs_cfg.svh
// constants for the conversion sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_MODE_OFF 2'h0
`define ACS_MODE_SINGLE 2'h1
`define ACS_MODE_REPEAT 2'h3
`define ACS_RES_W 10
`define ACS_CLK_MHZ 50
`define ACS_T0 10'h027
`define ACS_T1 10'h04E
`define ACS_T2 10'h09C
`define ACS_T3 10'h138
`define ACS_T4 10'h270
`endif

// >>> logic/acs_pkg.sv
// types for the conversion sequencer
package acs_pkg;
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] chan;
        logic gate;
        logic [2:0] time_sel;
    } acs_cfg_s;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'h0,
        ACS_CONV = 2'h1
    } acs_state_e;
endpackage : acs_pkg

// >>> logic/acs_sequencer.sv
// conversion sequencer for a 10-bit successive-approximation converter
`include "acs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
    // counter width, wide enough for the longest conversion
    parameter int CNT_W = 10
) (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // software control
    input wire acs_pkg::acs_cfg_s cfg_in,
    input wire logic cfg_wr_in,
    input wire logic start_wr_in,
    input wire logic low_rd_in,
    input wire logic high_rd_in,
    input wire logic low_power_in,
    // analog core
    input wire logic [`ACS_RES_W-1:0] core_code_in,
    output logic sample_out,
    output logic [3:0] chan_out,
    output logic gate_out,
    // status and results
    output logic [1:0] mode_out,
    output logic start_trig_out,
    output logic busy_out,
    output logic done_out,
    output logic done_irq_out,
    output logic [7:0] result_low_out,
    output logic [7:0] result_high_out
);
    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // count loaded at start: conversion length minus one
    function automatic logic [CNT_W-1:0] conv_load(input logic [2:0] sel);
        logic [CNT_W-1:0] len;
        len = CNT_W'(`ACS_T4);
        case (sel)
            3'h0: len = CNT_W'(`ACS_T0);
            3'h1: len = CNT_W'(`ACS_T1);
            3'h2: len = CNT_W'(`ACS_T2);
            3'h3: len = CNT_W'(`ACS_T3);
            default: len = CNT_W'(`ACS_T4);
        endcase
        return len - CNT_W'(1);
    endfunction : conv_load

    // modes that run conversions
    function automatic logic run_mode(input logic [1:0] mode);
        return (mode == `ACS_MODE_SINGLE) || (mode == `ACS_MODE_REPEAT);
    endfunction : run_mode

    // repeat mode keeps converting after each completion
    function automatic logic is_repeat(input logic [1:0] mode);
        return mode == `ACS_MODE_REPEAT;
    endfunction : is_repeat

    // ----------------------------------------
    // state
    // ----------------------------------------
    // registered state
    acs_pkg::acs_state_e st_q, st_d;
    acs_pkg::acs_cfg_s cfg_q, cfg_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic start_q, start_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic irq_q, irq_d;
    logic low_read_q, low_read_d;
    logic sample_q, sample_d;
    logic [`ACS_RES_W-1:0] res_q, res_d;

    // decoded events
    logic launch;
    logic finish;
    logic store;
    logic off_wr;
    logic abort;

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    always_comb begin
        launch = 1'b0;
        finish = 1'b0;
        unique case (st_q)
            acs_pkg::ACS_IDLE: begin
                launch = start_q && run_mode(cfg_q.mode);
            end
            acs_pkg::ACS_CONV: begin
                finish = (cnt_q == '0);
            end
            default: begin
                finish = 1'b0;
            end
        endcase
        // a completion after a lone low read is dropped
        store = finish && (!(low_read_q || low_rd_in) || high_rd_in);
        off_wr = cfg_wr_in && (cfg_in.mode == `ACS_MODE_OFF);
        abort = off_wr || low_power_in;
    end

    // ----------------------------------------
    // configuration and start trigger
    // ----------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        start_d = start_q;
        if (cfg_wr_in) begin
            cfg_d = cfg_in;
        end
        if (start_wr_in) begin
            start_d = 1'b1;
        end
        if (launch) begin
            start_d = start_wr_in;
        end
        if (off_wr) begin
            start_d = 1'b0;
        end
        if (low_power_in) begin
            cfg_d.mode = `ACS_MODE_OFF;
            cfg_d.gate = 1'b0;
            start_d = 1'b0;
        end
    end

    // registers, frozen while the enable is low
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q <= '0;
            start_q <= 1'b0;
        end else if (clk_en_in) begin
            cfg_q <= cfg_d;
            start_q <= start_d;
        end
    end

    // ----------------------------------------
    // conversion sequencing
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sample_d = finish;
        unique case (st_q)
            acs_pkg::ACS_IDLE: begin
                if (launch) begin
                    st_d = acs_pkg::ACS_CONV;
                    cnt_d = conv_load(cfg_q.time_sel);
                end
            end
            acs_pkg::ACS_CONV: begin
                if (!finish) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else if (is_repeat(cfg_q.mode)) begin
                    cnt_d = conv_load(cfg_q.time_sel);
                end else begin
                    st_d = acs_pkg::ACS_IDLE;
                end
            end
            default: begin
                st_d = acs_pkg::ACS_IDLE;
            end
        endcase
        if (abort) begin
            st_d = acs_pkg::ACS_IDLE;
            sample_d = 1'b0;
        end
    end

    // registers, frozen while the enable is low
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= acs_pkg::ACS_IDLE;
            cnt_q <= '0;
            sample_q <= 1'b0;
        end else if (clk_en_in) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sample_q <= sample_d;
        end
    end

    // ----------------------------------------
    // busy, done and interrupt flags
    // ----------------------------------------
    always_comb begin
        busy_d = busy_q;
        done_d = done_q;
        irq_d = 1'b0;
        low_read_d = low_read_q;
        if (low_rd_in) begin
            low_read_d = 1'b1;
        end
        if (high_rd_in) begin
            low_read_d = 1'b0;
            done_d = 1'b0;
        end
        if (launch) begin
            busy_d = 1'b1;
            done_d = 1'b0;
        end
        // a set on completion wins over a clearing high read
        if (store) begin
            done_d = 1'b1;
            irq_d = 1'b1;
        end
        if (finish && !is_repeat(cfg_q.mode)) begin
            busy_d = 1'b0;
        end
        if (abort) begin
            busy_d = 1'b0;
            done_d = 1'b0;
            irq_d = 1'b0;
            low_read_d = 1'b0;
        end
    end

    // registers, frozen while the enable is low
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            irq_q <= 1'b0;
            low_read_q <= 1'b0;
        end else if (clk_en_in) begin
            busy_q <= busy_d;
            done_q <= done_d;
            irq_q <= irq_d;
            low_read_q <= low_read_d;
        end
    end

    // ----------------------------------------
    // result register
    // ----------------------------------------
    always_comb begin
        res_d = res_q;
        if (store) begin
            res_d = core_code_in;
        end
        if (abort) begin
            res_d = '0;
        end
    end

    // registers, frozen while the enable is low
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_q <= '0;
        end else if (clk_en_in) begin
            res_q <= res_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // analog core side
    assign sample_out = sample_q;
    assign chan_out = cfg_q.chan;
    assign gate_out = cfg_q.gate;
    // status flags
    assign mode_out = cfg_q.mode;
    assign start_trig_out = start_q;
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign done_irq_out = irq_q;
    // result bytes
    assign result_low_out = res_q[7:0];
    assign result_high_out = {6'h00, res_q[9:8]};
endmodule : acs_sequencer
`default_nettype wire

// >>> test/acs_core_model.sv
// analog core model for the conversion sequencer bench
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
    // selection from the sequencer, level from the bench
    input wire logic [3:0] chan_in,
    input wire logic gate_in,
    input wire logic [5:0] level_in,
    // code back to the sequencer
    output logic [9:0] code_out
);
    // gated-off input reads as a pattern, not a held value
    assign code_out = gate_in ? {chan_in, level_in} : 10'h2AA;
endmodule : acs_core_model
`default_nettype wire

// >>> test/acs_properties.sv
// assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_properties (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // software control
    input wire acs_pkg::acs_cfg_s cfg_in,
    input wire logic cfg_wr_in,
    input wire logic high_rd_in,
    input wire logic low_power_in,
    // status and results
    input wire logic sample_out,
    input wire logic [1:0] mode_out,
    input wire logic start_trig_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic done_irq_out,
    input wire logic [7:0] result_low_out,
    input wire logic [7:0] result_high_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_trig_self_clear: assert property (start_trig_out && mode_out[0] |=> !start_trig_out)
        else $error("start trigger stayed set");
    a_busy_from_trig: assert property ($rose(busy_out) |-> $past(start_trig_out))
        else $error("busy rose without start");
    a_conv_min_len: assert property ($rose(busy_out) |-> !done_irq_out [*8])
        else $error("conversion ended too soon");
    a_irq_one_cycle: assert property (done_irq_out && clk_en_in |=> !done_irq_out)
        else $error("done irq longer than one cycle");
    a_irq_with_flags: assert property (done_irq_out |-> done_out && (mode_out == 2'h3 || !busy_out))
        else $error("flags wrong at completion");
    a_done_needs_irq: assert property ($rose(done_out) |-> done_irq_out)
        else $error("done flag set without irq");
    a_high_rd_clear: assert property (high_rd_in && clk_en_in && !low_power_in
        |=> !done_out || done_irq_out)
        else $error("high read left done set");
    a_high_zero: assert property (result_high_out[7:2] == 6'h0)
        else $error("high result upper bits set");
    a_off_clears: assert property (cfg_wr_in && clk_en_in && cfg_in.mode == 2'h0
        |=> !busy_out && !done_out
        && result_low_out == 8'h0 && result_high_out == 8'h0)
        else $error("disable did not clear");
    a_sleep_clears: assert property (low_power_in && clk_en_in |=> mode_out == 2'h0 && !busy_out
        && !start_trig_out && !done_out)
        else $error("low power did not clear");
    a_no_resume: assert property ($fell(low_power_in) |=> !busy_out)
        else $error("conversion resumed after low power");
    a_freeze_holds: assert property (!clk_en_in
        |=> $stable({busy_out, done_out, mode_out, result_low_out}))
        else $error("state moved while enable low");
    a_sample_with_irq: assert property (done_irq_out |-> sample_out)
        else $error("completion without capture marker");
endmodule : acs_properties
bind acs_sequencer acs_properties i_props (.*);
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk_in = 0, rst_n_in = 0, clk_en_in = 1, cfg_wr_in = 0, start_wr_in = 0;
    logic low_rd_in = 0, high_rd_in = 0, low_power_in = 0;
    logic sample_out, gate_out, start_trig_out, busy_out, done_out, done_irq_out;
    logic [1:0] mode_out;
    logic [3:0] chan_out, ch;
    logic [5:0] level_in = 0, l;
    logic [7:0] result_low_out, result_high_out;
    logic [9:0] core_code_in;
    logic [19:0] e;
    logic [19:0] expq [$];
    acs_pkg::acs_cfg_s cfg_in = '0;
    int err_total = 0, samples_checked = 0, seed = 32'h30CC, cnt = 0;
    initial forever #10 ref_clk_in = ~ref_clk_in;
    acs_sequencer i_dut (.*);
    acs_core_model i_core (.chan_in(chan_out), .gate_in(gate_out), .level_in(level_in),
        .code_out(core_code_in));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : cyc
    task automatic chk(input logic [9:0] g, input logic [9:0] x);
        samples_checked++;
        if (g !== x) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [1:0] m, input logic [2:0] t);
        ch = 4'($random(seed));
        l = 6'($random(seed));
        level_in <= l;
        cfg_in <= '{m, ch, 1'b1, t};
        cfg_wr_in <= 1;
        cyc(1);
        cfg_wr_in <= 0;
    endtask : wr
    task automatic st;
        start_wr_in <= 1;
        cyc(1);
        start_wr_in <= 0;
    endtask : st
    task automatic rd(input logic h);
        low_rd_in <= !h;
        high_rd_in <= h;
        cyc(1);
        low_rd_in <= 0;
        high_rd_in <= 0;
    endtask : rd
    task automatic wirq;
        int i;
        i = 0;
        while (i < 900 && done_irq_out !== 1'b1) begin
            cyc(1);
            i++;
        end
        chk(10'(i < 900), 10'h1);
        cyc(1);
    endtask : wirq
    // result watcher: oldest note against each completion
    always @(posedge ref_clk_in) begin
        cnt <= busy_out ? cnt + 1 : 0;
        if (done_irq_out === 1'b1 && expq.size() == 0) chk(10'h3FF, 10'h0);
        else if (done_irq_out === 1'b1) begin
            e = expq.pop_front();
            chk({result_high_out[1:0], result_low_out}, e[9:0]);
            if (e[19:10] != 0) chk(10'(cnt), e[19:10]);
        end
    end
    initial begin
        cyc(12);
        rst_n_in <= 1;
        cyc(1);
        for (int t = 0; t < 8; t++) begin
            wr(2'h1, 3'(t));
            expq.push_back({10'd39 << (t > 4 ? 4 : t), ch, l});
            st();
            wirq();
            rd(0);
            rd(1);
        end
        expq.push_back({10'd624, ch, l});
        st();
        wirq();
        level_in <= ~l;
        expq.push_back({10'd624, ch, ~l});
        st();
        cyc(2);
        chk(done_out, 0);
        chk(result_low_out, {ch[1:0], l});
        wirq();
        wr(2'h3, 3'h0);
        repeat (2) expq.push_back({10'h0, ch, l});
        st();
        wirq();
        wirq();
        rd(0);
        level_in <= ~l;
        cyc(40);
        clk_en_in <= 0;
        cyc(10);
        chk(busy_out, 1);
        clk_en_in <= 1;
        cyc(50);
        chk(result_low_out, {ch[1:0], l});
        expq.push_back({10'h0, ch, ~l});
        rd(1);
        wirq();
        wr(2'h0, 3'h0);
        cyc(1);
        chk(busy_out, 0);
        chk(result_low_out, 0);
        wr(2'h1, 3'h4);
        st();
        cyc(50);
        low_power_in <= 1;
        cyc(1);
        low_power_in <= 0;
        cyc(1);
        chk(mode_out, 0);
        wr(2'h2, 3'h0);
        st();
        cyc(50);
        chk(busy_out, 0);
        cyc(700);
        chk(10'(expq.size()), 0);
        complete_run();
    end
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
